// File: design/sdg_ctrl.sv
// Scan sequencer, keypad debouncer, GPIO pads, serial port and register slave.
//
// The register offsets and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
module sdg_ctrl import sdg_pkg::*; #(
  parameter int SETTLE_UNIT_CYCLES = SETTLE_UNIT_CYC,
  parameter int DEBOUNCE_UNIT_CYCLES = DEBOUNCE_UNIT_CYC
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Avalon-MM register slave.
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Serial host port.
  input wire logic i_cs_n,
  input wire logic i_serial_clock_pin,
  input wire logic i_din,
  output logic o_dout,
  // Touch detector and converter.
  input wire logic i_touch,
  input wire logic i_conv_done,
  input wire logic [11:0] i_conv_data,
  output logic o_conv_start,
  output logic [3:0] o_conv_ch,
  // Keypad and GPIO pads, rows 0 to 3, columns 4 to 7.
  input wire logic [7:0] i_kp_pin,
  output logic [7:0] o_kp_pin_out,
  output logic [7:0] o_kp_pin_oe_n,
  // Interrupt lines to the host.
  output logic o_touch_irq_n,
  output logic o_key_irq_n
);

  sdg_state_t st; // Registered state.
  sdg_state_t nx; // Next state.

  logic av_req; // A bus request is present.
  logic wr_en; // One register write this cycle.
  logic [4:0] wr_addr; // Index of that write.
  logic [15:0] wr_data; // Data of that write.
  logic ser_rise; // Rising serial clock seen.
  logic ser_fall; // Falling serial clock seen.
  logic [9:0] cmd_mask; // Channels a control write asks for.
  logic [9:0] launch_mask; // Channels of a scan starting now.
  logic host_key_start; // Keypad control write in host mode.
  logic auto_t; // Touch-initiated mode.
  logic host_t; // Host-initiated touch mode.
  logic auto_k; // Key-press-initiated mode.
  logic host_k; // Host-initiated debounce mode.
  logic [3:0] rows_low; // Keypad rows pulled low by a key.
  logic key_down; // Any keypad row low.
  logic [3:0] col_drive; // Columns driven low.
  logic [15:0] snap_new; // Snapshot with the current column merged.
  logic [3:0] nch; // Next channel of a running scan.
  logic [7:0] gsel; // GPIO select bits.
  logic [7:0] goe; // GPIO output enable bits.

  // Channels measured by each scan function.
  function automatic logic [9:0] chan_mask(input logic [3:0] f);
    case (f)
      FUNC_XY: chan_mask = MASK_X | MASK_Y;
      FUNC_XYZ: chan_mask = MASK_X | MASK_Y | MASK_Z;
      FUNC_X: chan_mask = MASK_X;
      FUNC_Y: chan_mask = MASK_Y;
      FUNC_Z: chan_mask = MASK_Z;
      FUNC_HK: chan_mask = MASK_HK;
      default: chan_mask = 10'h000;
    endcase
  endfunction

  // Lowest selected channel at or above a start index.
  function automatic logic [3:0] next_ch(input logic [9:0] m, input logic [4:0] from);
    next_ch = CH_NONE;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (m[i] && (5'(i) >= from)) begin
        next_ch = 4'(i);
      end
    end
  endfunction

  // Register read view shared by the bus and the serial port.
  function automatic logic [15:0] reg_read(input sdg_state_t s, input logic [4:0] a);
    case (a)
      ADDR_ADC_CTRL: reg_read = s.adc_ctrl;
      ADDR_KEY_CTRL: reg_read = s.key_ctrl;
      ADDR_GPIO_CTRL: reg_read = s.gpio_ctrl;
      ADDR_GPIO_DATA: reg_read = {s.pin_s2, 8'h00};
      ADDR_GPIO_PUD: reg_read = {s.pud, 8'h00};
      ADDR_KEY_MASK: reg_read = s.key_mask;
      ADDR_KEY_STATUS: reg_read = s.key_pend & ~s.key_mask;
      ADDR_KEY_PEND: reg_read = s.key_pend;
      ADDR_SCAN_STAT: reg_read = {s.tstate != T_IDLE, s.kstate == K_SCAN, s.touch_s2, 13'h0000};
      default: begin
        if (a >= ADDR_RES_BASE && a <= ADDR_RES_LAST) begin
          reg_read = {4'h0, s.res[4'(a - ADDR_RES_BASE)]};
        end else begin
          reg_read = 16'h0000;
        end
      end
    endcase
  endfunction

  // Cycle-settling delay chosen by the settle field.
  function automatic logic [23:0] settle_cycles(input logic [2:0] sel);
    settle_cycles = 24'(SETTLE_MULT[sel] * SETTLE_UNIT_CYCLES);
  endfunction

  // Debounce period in cycles chosen by the period field.
  function automatic logic [23:0] debounce_cycles(input logic [2:0] sel);
    debounce_cycles = 24'(DEBOUNCE_MS[sel] * DEBOUNCE_UNIT_CYCLES);
  endfunction

  // Next-state logic for every part of the block.
  always_comb begin
    nx = st;
    wr_en = 1'b0;
    wr_addr = 5'h00;
    wr_data = 16'h0000;
    cmd_mask = 10'h000;
    launch_mask = 10'h000;
    host_key_start = 1'b0;
    col_drive = 4'h0;
    snap_new = st.snap;
    nch = CH_NONE;
    nx.conv_start = 1'b0;

    // Pins and serial lines pass two flip-flops; the third serial stage only finds edges.
    nx.pin_s1 = i_kp_pin;
    nx.pin_s2 = st.pin_s1;
    nx.ser_s1 = '{cs_n: i_cs_n, sclk: i_serial_clock_pin, din: i_din};
    nx.ser_s2 = st.ser_s1;
    nx.ser_d3 = st.ser_s2;
    nx.touch_s1 = i_touch;
    nx.touch_s2 = st.touch_s1;

    // Bus slave: one wait cycle, then the answer; writes land at the edge that sees waitrequest low.
    av_req = i_avs_read | i_avs_write;
    nx.waitreq = 1'b1;
    if (av_req && st.waitreq) begin
      nx.waitreq = 1'b0;
      nx.rdata = reg_read(st, i_avs_address);
    end
    if (av_req && !st.waitreq && i_avs_write) begin
      wr_en = 1'b1;
      wr_addr = i_avs_address;
      wr_data = i_avs_writedata[15:0];
    end else if (st.wr_pend) begin
      // A serial write waits here when the bus claims the write port.
      wr_en = 1'b1;
      wr_addr = st.wr_addr;
      wr_data = st.wr_data;
      nx.wr_pend = 1'b0;
    end

    // Serial port: command word then data word, both most significant bit first.
    ser_rise = st.ser_s2.sclk && !st.ser_d3.sclk;
    ser_fall = !st.ser_s2.sclk && st.ser_d3.sclk;
    if (st.ser_s2.cs_n) begin
      nx.bitcnt = 6'h00;
      nx.dout = 1'b0;
    end else begin
      if (ser_rise && st.bitcnt < SER_FRAME_BITS) begin
        nx.bitcnt = st.bitcnt + 6'h01;
        if (st.bitcnt < SER_CMD_BITS) begin
          nx.cmd = {st.cmd[14:0], st.ser_s2.din};
        end else begin
          nx.shin = {st.shin[14:0], st.ser_s2.din};
        end
        if (st.bitcnt == SER_CMD_BITS - 6'h01) begin
          nx.shout = reg_read(st, {st.cmd[3:0], st.ser_s2.din});
        end
        if (st.bitcnt == SER_FRAME_BITS - 6'h01 && !st.cmd[SER_RD_BIT]) begin
          nx.wr_pend = 1'b1;
          nx.wr_addr = st.cmd[4:0];
          nx.wr_data = {st.shin[14:0], st.ser_s2.din};
        end
      end
      // Output moves only on falling edges so the host samples a settled bit on rising ones.
      if (ser_fall && st.bitcnt >= SER_CMD_BITS) begin
        nx.dout = st.shout[15];
        nx.shout = {st.shout[14:0], 1'b0};
      end
    end

    // Mode decode from the stored control words.
    auto_t = st.adc_ctrl[ADC_TSS_BIT] && !st.adc_ctrl[ADC_ASS_BIT];
    host_t = !st.adc_ctrl[ADC_TSS_BIT] && !st.adc_ctrl[ADC_ASS_BIT];
    auto_k = st.key_ctrl[KEY_HI_BIT] && !st.key_ctrl[KEY_LO_BIT];
    host_k = !st.key_ctrl[KEY_HI_BIT] && !st.key_ctrl[KEY_LO_BIT];

    // Register writes and their side effects.
    if (wr_en) begin
      case (wr_addr)
        ADDR_ADC_CTRL: begin
          nx.adc_ctrl = wr_data;
          if (wr_data[ADC_FUNC_LSB +: 4] == FUNC_HK) begin
            cmd_mask = MASK_HK;
          end else if (!wr_data[ADC_TSS_BIT] && !wr_data[ADC_ASS_BIT]) begin
            cmd_mask = chan_mask(wr_data[ADC_FUNC_LSB +: 4]);
          end
        end
        ADDR_KEY_CTRL: begin
          nx.key_ctrl = wr_data;
          host_key_start = !wr_data[KEY_HI_BIT] && !wr_data[KEY_LO_BIT];
        end
        ADDR_GPIO_CTRL: nx.gpio_ctrl = wr_data;
        ADDR_GPIO_DATA: nx.gpio_out = wr_data[15:8];
        ADDR_GPIO_PUD: nx.pud = wr_data[15:8];
        ADDR_KEY_MASK: nx.key_mask = wr_data;
        default: begin
          // Read-only and unmapped indices ignore writes.
        end
      endcase
    end

    // Touch interrupt only in host mode while the sequencer waits.
    nx.touch_irq_n = !(host_t && st.touch_s2 && st.tstate == T_IDLE);

    // Scan sequencer.
    case (st.tstate)
      T_IDLE: begin
        if (cmd_mask != 10'h000) begin
          launch_mask = cmd_mask;
        end else if (auto_t && st.touch_s2) begin
          nx.settle_cnt = settle_cycles(st.adc_ctrl[ADC_SETTLE_LSB +: 3]);
          nx.tstate = T_SETTLE;
        end
      end
      T_SETTLE: begin
        // A lifted touch during settling abandons the scan rather than convert noise.
        if (!st.touch_s2) begin
          nx.tstate = T_IDLE;
        end else if (st.settle_cnt == 24'h000000) begin
          launch_mask = chan_mask(st.adc_ctrl[ADC_FUNC_LSB +: 4]);
          nx.tstate = T_IDLE;
        end else begin
          nx.settle_cnt = st.settle_cnt - 24'h000001;
        end
      end
      T_CONV: begin
        nx.conv_start = 1'b1;
        nx.tstate = T_WAIT;
      end
      T_WAIT: begin
        if (i_conv_done) begin
          nx.res[st.ch] = i_conv_data;
          nch = next_ch(st.ch_mask, {1'b0, st.ch} + 5'h01);
          if (nch == CH_NONE) begin
            nx.tstate = T_IDLE;
          end else begin
            nx.ch = nch;
            nx.tstate = T_CONV;
          end
        end
      end
      default: nx.tstate = T_IDLE;
    endcase
    if (launch_mask != 10'h000) begin
      nx.ch_mask = launch_mask;
      nx.ch = next_ch(launch_mask, 5'h00);
      nx.tstate = T_CONV;
    end

    // Keypad: rows read low through a pressed key on a driven column.
    gsel = st.gpio_ctrl[15:8];
    goe = st.gpio_ctrl[7:0];
    rows_low = ~st.pin_s2[3:0] & ~gsel[3:0];
    key_down = |rows_low;
    nx.key_irq_n = !(host_k && key_down && st.kstate == K_IDLE);

    case (st.kstate)
      K_IDLE: begin
        col_drive = 4'hF;
        if ((auto_k && key_down) || host_key_start) begin
          nx.kstate = K_SCAN;
          nx.col = 2'b00;
          nx.col_cnt = 4'h0;
          nx.db_cnt = 24'h000000;
        end
      end
      K_SCAN: begin
        col_drive = 4'b0001 << st.col;
        nx.db_cnt = st.db_cnt + 24'h000001;
        nx.col_cnt = st.col_cnt + 4'h1;
        if (st.col_cnt == COL_SETTLE_CYC) begin
          nx.col_cnt = 4'h0;
          snap_new[{st.col, 2'b00} +: 4] = rows_low;
          nx.snap = snap_new;
          nx.col = st.col + 2'b01;
          if (st.col == 2'b11) begin
            // Any change restarts the period, so only a full quiet period counts.
            if (snap_new != st.last) begin
              nx.db_cnt = 24'h000000;
              nx.last = snap_new;
            end else if (st.db_cnt >= debounce_cycles(st.key_ctrl[KEY_DBN_LSB +: 3])) begin
              nx.key_pend = snap_new;
              nx.kstate = K_RELEASE;
            end
          end
        end
      end
      K_RELEASE: begin
        // Waiting for release keeps a held key from being debounced over and over.
        col_drive = 4'hF;
        if (!key_down) begin
          nx.kstate = K_IDLE;
        end
      end
      default: nx.kstate = K_IDLE;
    endcase

    // Pad drivers: GPIO pins first, then keypad columns.
    for (int i = 0; i < 8; i++) begin
      nx.pin_out[i] = 1'b0;
      nx.pin_oe_n[i] = 1'b1;
      if (gsel[i] && goe[i]) begin
        nx.pin_out[i] = st.gpio_out[i];
        nx.pin_oe_n[i] = st.pud[i] & st.gpio_out[i];
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (!gsel[4 + i] && col_drive[i]) begin
        nx.pin_out[4 + i] = 1'b0;
        nx.pin_oe_n[4 + i] = 1'b0;
      end
    end
  end

  // State register; reset loads constants only.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
      st.waitreq <= 1'b1;
      st.ser_s1 <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
      st.ser_s2 <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
      st.ser_d3 <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
      st.pin_s1 <= 8'hFF;
      st.pin_s2 <= 8'hFF;
      st.adc_ctrl <= ADC_CTRL_RST;
      st.key_ctrl <= KEY_CTRL_RST;
      st.gpio_ctrl <= GPIO_CTRL_RST;
      st.tstate <= T_IDLE;
      st.kstate <= K_IDLE;
      st.touch_irq_n <= 1'b1;
      st.key_irq_n <= 1'b1;
      st.pin_oe_n <= 8'hFF;
    end else begin
      st <= nx;
    end
  end

  // Outputs straight from the state register.
  assign o_avs_readdata = {16'h0000, st.rdata};
  assign o_avs_waitrequest = st.waitreq;
  assign o_dout = st.dout;
  assign o_conv_start = st.conv_start;
  assign o_conv_ch = st.ch;
  assign o_kp_pin_out = st.pin_out;
  assign o_kp_pin_oe_n = st.pin_oe_n;
  assign o_touch_irq_n = st.touch_irq_n;
  assign o_key_irq_n = st.key_irq_n;

endmodule

// File: pkg/sdg_pkg.sv
// Constants, carrier types and register layout for the scan, debounce and GPIO controller.
// Operation
// - Housekeeping function measures batteries, auxiliaries, temperatures.
// - Each measurement lands in its own result.
// - Auto touch mode scans on detected touch.
// - Touch scan channels follow stored function field.
// - Host touch mode raises touch interrupt only.
// - Auto key mode debounces on key press.
// - Key scan starts on press (auto) or key control write (host), ends debounced.
// - Host key mode raises key interrupt only.
// - Debounce period comes from period field.
// - Debounced only after one stable whole period.
// - Keys readable masked status and unmasked pending.
// - Mask bits hide keys in status only.
// - Select bits turn keypad pins into GPIO.
// - Output-enable bits set GPIO pin direction.
// - GPIO data read returns actual pin levels.
// - GPIO data write drives output pins only.
// - Outputs push-pull; pullup-disable bit makes open-drain.
// - Two command bytes, then two data bytes.
// - Data out changes on falling serial edges.
// - Selectable settling delay before touch scan; only touch-initiated scans wait for it.
package sdg_pkg;
  // Core clock and derived timing.
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETTLE_UNIT_US = 100;
  localparam int SETTLE_UNIT_CYC = SETTLE_UNIT_US * 1000 / CLK_PERIOD_NS;
  localparam int DEBOUNCE_UNIT_MS = 1;
  localparam int DEBOUNCE_UNIT_CYC = DEBOUNCE_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [3:0] COL_SETTLE_CYC = 4'hF;
  // Settling delay multiples of the unit; the last entry is 100 ms.
  localparam int SETTLE_MULT [8] = '{0, 1, 5, 10, 50, 100, 500, 1000};
  // Debounce periods in milliseconds.
  localparam int DEBOUNCE_MS [8] = '{2, 10, 20, 50, 60, 80, 100, 120};
  // Serial framing.
  localparam logic [5:0] SER_CMD_BITS = 6'h10;
  localparam logic [5:0] SER_FRAME_BITS = 6'h20;
  localparam int SER_RD_BIT = 15;
  // Register indices (byte address is four times the index).
  localparam logic [4:0] ADDR_ADC_CTRL = 5'h00;
  localparam logic [4:0] ADDR_KEY_CTRL = 5'h01;
  localparam logic [4:0] ADDR_GPIO_CTRL = 5'h02;
  localparam logic [4:0] ADDR_GPIO_DATA = 5'h03;
  localparam logic [4:0] ADDR_GPIO_PUD = 5'h04;
  localparam logic [4:0] ADDR_KEY_MASK = 5'h05;
  localparam logic [4:0] ADDR_KEY_STATUS = 5'h06;
  localparam logic [4:0] ADDR_KEY_PEND = 5'h07;
  localparam logic [4:0] ADDR_SCAN_STAT = 5'h08;
  localparam logic [4:0] ADDR_RES_BASE = 5'h10;
  localparam logic [4:0] ADDR_RES_LAST = 5'h19;
  // Field positions.
  localparam int ADC_TSS_BIT = 15;
  localparam int ADC_ASS_BIT = 14;
  localparam int ADC_FUNC_LSB = 10;
  localparam int ADC_SETTLE_LSB = 7;
  localparam int KEY_HI_BIT = 15;
  localparam int KEY_LO_BIT = 14;
  localparam int KEY_DBN_LSB = 11;
  // Reset values.
  localparam logic [15:0] ADC_CTRL_RST = 16'h0000;
  localparam logic [15:0] KEY_CTRL_RST = 16'h0000;
  localparam logic [15:0] GPIO_CTRL_RST = 16'h0000;
  // Channels and scan functions.
  localparam int NUM_CH = 10;
  localparam logic [3:0] CH_NONE = 4'hF;
  localparam logic [3:0] FUNC_XY = 4'h2;
  localparam logic [3:0] FUNC_XYZ = 4'h3;
  localparam logic [3:0] FUNC_X = 4'h4;
  localparam logic [3:0] FUNC_Y = 4'h5;
  localparam logic [3:0] FUNC_Z = 4'h6;
  localparam logic [3:0] FUNC_HK = 4'hB;
  localparam logic [9:0] MASK_X = 10'h001;
  localparam logic [9:0] MASK_Y = 10'h002;
  localparam logic [9:0] MASK_Z = 10'h00C;
  localparam logic [9:0] MASK_HK = 10'h3F0;

  typedef enum logic [1:0] {T_IDLE = 2'b00, T_SETTLE = 2'b01, T_CONV = 2'b10, T_WAIT = 2'b11} sdg_tstate_t;
  typedef enum logic [1:0] {K_IDLE = 2'b00, K_SCAN = 2'b01, K_RELEASE = 2'b10} sdg_kstate_t;

  // Serial pins travel together through the synchroniser.
  typedef struct packed {logic cs_n; logic sclk; logic din;} sdg_ser_t;

  // Whole state of the controller.
  typedef struct packed {
    logic waitreq;
    logic [15:0] rdata;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    sdg_ser_t ser_s1;
    sdg_ser_t ser_s2;
    sdg_ser_t ser_d3;
    logic touch_s1;
    logic touch_s2;
    logic [15:0] adc_ctrl;
    logic [15:0] key_ctrl;
    logic [15:0] gpio_ctrl;
    logic [7:0] gpio_out;
    logic [7:0] pud;
    logic [15:0] key_mask;
    logic [15:0] key_pend;
    logic [5:0] bitcnt;
    logic [15:0] cmd;
    logic [15:0] shin;
    logic [15:0] shout;
    logic dout;
    logic wr_pend;
    logic [4:0] wr_addr;
    logic [15:0] wr_data;
    sdg_tstate_t tstate;
    logic [23:0] settle_cnt;
    logic [9:0] ch_mask;
    logic [3:0] ch;
    logic conv_start;
    logic [9:0][11:0] res;
    sdg_kstate_t kstate;
    logic [1:0] col;
    logic [3:0] col_cnt;
    logic [15:0] snap;
    logic [15:0] last;
    logic [23:0] db_cnt;
    logic touch_irq_n;
    logic key_irq_n;
    logic [7:0] pin_out;
    logic [7:0] pin_oe_n;
  } sdg_state_t;
endpackage

// File: verif/sdg_ctrl_monitor.sv
// Port checker for the scan, debounce and GPIO controller.
`timescale 1ns/1ps
module sdg_ctrl_monitor #(
  parameter int SETTLE_UNIT_CYCLES = 4,
  parameter int DEBOUNCE_UNIT_CYCLES = 8
) (
  // All ports of the controller, seen as inputs.
  input wire logic i_core_clk, i_rst_n, i_avs_read, i_avs_write, o_avs_waitrequest,
  input wire logic [4:0] i_avs_address,
  input wire logic [31:0] i_avs_writedata, o_avs_readdata,
  input wire logic i_cs_n, i_serial_clock_pin, i_din, o_dout,
  input wire logic i_touch, i_conv_done, o_conv_start,
  input wire logic [11:0] i_conv_data,
  input wire logic [3:0] o_conv_ch,
  input wire logic [7:0] i_kp_pin, o_kp_pin_out, o_kp_pin_oe_n,
  input wire logic o_touch_irq_n, o_key_irq_n
);
  // One clock domain, so clock and reset are given once.
  default clocking mon_cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  AST_WAIT_ONE: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("register request not answered after one cycle");
  AST_WAIT_SINGLE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("answer held longer than one cycle");
  AST_NO_SPURIOUS: assert property (!o_avs_waitrequest |-> $past(i_avs_read || i_avs_write))
    else $error("answer without a request");
  AST_RDATA_HI: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  AST_CONV_PULSE: assert property (o_conv_start |=> !o_conv_start)
    else $error("conversion start longer than one cycle");
  AST_CONV_CH: assert property (o_conv_start |-> o_conv_ch <= 4'h9)
    else $error("conversion of a channel that does not exist");
  AST_DOUT_IDLE: assert property (i_cs_n [*5] |-> !o_dout)
    else $error("serial output not idle while deselected");
  AST_DOUT_FALL: assert property ($changed(o_dout) |-> !i_serial_clock_pin)
    else $error("serial output changed while serial clock high");
  AST_TOUCH_CAUSE: assert property (!o_touch_irq_n |-> $past(i_touch, 3) || $past(i_touch, 4))
    else $error("touch interrupt without a touch");
endmodule

bind sdg_ctrl sdg_ctrl_monitor #(
  .SETTLE_UNIT_CYCLES(SETTLE_UNIT_CYCLES),
  .DEBOUNCE_UNIT_CYCLES(DEBOUNCE_UNIT_CYCLES)
) u_mon (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .i_avs_address(i_avs_address), .i_avs_writedata(i_avs_writedata),
  .o_avs_readdata(o_avs_readdata), .i_cs_n(i_cs_n), .i_serial_clock_pin(i_serial_clock_pin), .i_din(i_din),
  .o_dout(o_dout), .i_touch(i_touch), .i_conv_done(i_conv_done), .o_conv_start(o_conv_start),
  .i_conv_data(i_conv_data), .o_conv_ch(o_conv_ch), .i_kp_pin(i_kp_pin), .o_kp_pin_out(o_kp_pin_out),
  .o_kp_pin_oe_n(o_kp_pin_oe_n), .o_touch_irq_n(o_touch_irq_n), .o_key_irq_n(o_key_irq_n)
);

// File: verif/sdg_host_model.sv
// Serial host model that sends four-byte frames in clock mode zero.
`timescale 1ns/1ps
module sdg_host_model #(
  parameter int HALF = 10
) (
  // Core clock paces the serial clock, and the reply line.
  input wire logic i_clk,
  input wire logic i_dout,
  // Serial lines towards the controller.
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_din
);
  // The serial clock rests low between frames.
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_din = 1'b1;
  end
  // One frame, MSB first; the reply is taken at each rising serial edge.
  task automatic xfer(input logic [31:0] frame, output logic [15:0] rd);
    rd = 16'h0000;
    repeat (HALF) @(posedge i_clk);
    o_cs_n <= 1'b0;
    for (int b = 31; b >= 0; b--) begin
      o_din <= frame[b];
      repeat (HALF) @(posedge i_clk);
      o_sclk <= 1'b1;
      rd = {rd[14:0], i_dout};
      repeat (HALF) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
    repeat (HALF) @(posedge i_clk);
    o_cs_n <= 1'b1;
    // A released data line must not keep looking valid.
    o_din <= ~frame[0];
  endtask
endmodule

// File: verif/test_sdg_ctrl.sv
// Self-checking bench for the scan, debounce and GPIO controller.
`timescale 1ns/1ps
module test_sdg_ctrl import sdg_pkg::*;;
  logic i_core_clk = 1'b0, i_rst_n = 1'b0, rd_r = 1'b0, wr_r = 1'b0, touch = 1'b0, cdone = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdat = 32'h0, q;
  logic [15:0] rd16, seen = 16'h0;
  logic [11:0] cdata = 12'h000;
  logic [2:0] cpipe = 3'h0;
  logic [3:0] cch = 4'h0;
  logic [7:0] ext_n = 8'hFF, lvl, pad;
  logic kdn = 1'b0;
  logic [1:0] kr = 2'h0, kc = 2'h0;
  int n_errors = 0, comparisons = 0, pn;
  wire logic [31:0] rdata;
  wire logic wreq, cs_n, sclk, din, dout, cstart, tirq_n, kirq_n;
  wire logic [3:0] cch_o;
  wire logic [7:0] pout, poe_n;
  // Short units keep settle and debounce counts within a brief run.
  sdg_ctrl #(.SETTLE_UNIT_CYCLES(4), .DEBOUNCE_UNIT_CYCLES(8)) uut (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_avs_address(addr), .i_avs_read(rd_r), .i_avs_write(wr_r),
    .i_avs_writedata(wdat), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_cs_n(cs_n),
    .i_serial_clock_pin(sclk), .i_din(din), .o_dout(dout), .i_touch(touch), .i_conv_done(cdone),
    .i_conv_data(cdata), .o_conv_start(cstart), .o_conv_ch(cch_o), .i_kp_pin(pad), .o_kp_pin_out(pout),
    .o_kp_pin_oe_n(poe_n), .o_touch_irq_n(tirq_n), .o_key_irq_n(kirq_n));
  sdg_host_model #(.HALF(10)) host (.i_clk(i_core_clk), .i_dout(dout), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));
  initial forever #4 i_core_clk = ~i_core_clk;
  // Converter: answers four cycles late with a value that names the channel.
  always @(posedge i_core_clk) begin
    cpipe <= {cpipe[1:0], cstart};
    if (cstart) begin
      cch <= cch_o;
      seen[cch_o] <= 1'b1;
    end
    cdone <= cpipe[2];
    cdata <= 12'h800 | {8'h00, cch};
  end
  // Pads: pulled up when released; a pressed key joins its row and column.
  always_comb begin
    lvl = (pout | poe_n) & ext_n;
    pad = lvl;
    if (kdn) begin
      pad[kr] = lvl[kr] & lvl[4 + kc];
      pad[4 + kc] = pad[kr];
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    $display("[ERR] %0t timeout %h %h", $time, 1'b0, 1'b1);
    tally_and_finish();
  endtask
  // One register access; the request holds until waitrequest is seen low.
  task automatic av(input logic w, input logic [4:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge i_core_clk);
    addr <= a;
    wdat <= {16'h0000, d};
    wr_r <= w;
    rd_r <= ~w;
    do begin
      @(posedge i_core_clk);
      n++;
      if (n > 40) hang();
    end while (wreq !== 1'b0);
    q = rdata;
    rd_r <= 1'b0;
    wr_r <= 1'b0;
  endtask
  // Reads until the masked field matches; pn counts the reads.
  task automatic poll(input logic [4:0] a, input logic [15:0] m, input logic [15:0] v);
    pn = 0;
    do begin
      av(1'b0, a, 16'h0000);
      pn++;
      if (pn > 400) hang();
    end while ((q[15:0] & m) !== v);
  endtask
  task automatic wlow(input logic k);
    int n;
    n = 0;
    while ((k ? kirq_n : tirq_n) !== 1'b0) begin
      @(posedge i_core_clk);
      n++;
      if (n > 300) hang();
    end
  endtask
  task automatic t_regs();
    chk({24'h0, poe_n}, 32'h0F);
    av(1'b0, ADDR_GPIO_CTRL, 16'h0000);
    chk(q, {16'h0, GPIO_CTRL_RST});
    av(1'b0, ADDR_KEY_CTRL, 16'h0000);
    chk(q, {16'h0, KEY_CTRL_RST});
    av(1'b0, 5'h0C, 16'h0000);
    chk(q, 32'h0);
    av(1'b1, ADDR_KEY_PEND, 16'hFFFF);
    av(1'b0, ADDR_KEY_PEND, 16'h0000);
    chk(q, 32'h0);
  endtask
  task automatic t_hk();
    seen <= 16'h0000;
    av(1'b1, ADDR_ADC_CTRL, {2'b00, FUNC_HK, 10'h000});
    poll(ADDR_SCAN_STAT, 16'h8000, 16'h0000);
    chk({16'h0, seen}, 32'h3F0);
    for (int c = 4; c < 10; c++) begin
      av(1'b0, ADDR_RES_BASE + 5'(c), 16'h0000);
      chk(q, 32'h800 | c);
    end
  endtask
  task automatic t_thost();
    logic [3:0] fn [5] = '{FUNC_XY, FUNC_XYZ, FUNC_X, FUNC_Y, FUNC_Z};
    logic [15:0] ms [5] = '{16'h3, 16'hF, 16'h1, 16'h2, 16'hC};
    av(1'b1, ADDR_ADC_CTRL, 16'h0000);
    seen <= 16'h0000;
    touch <= 1'b1;
    wlow(1'b0);
    chk({16'h0, seen}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      seen <= 16'h0000;
      av(1'b1, ADDR_ADC_CTRL, {2'b00, fn[i], 10'h000});
      poll(ADDR_SCAN_STAT, 16'h8000, 16'h0000);
      chk({16'h0, seen}, {16'h0, ms[i]});
    end
    touch <= 1'b0;
  endtask
  task automatic t_tauto();
    int n;
    n = 0;
    av(1'b1, ADDR_ADC_CTRL, {2'b10, FUNC_X, 3'h2, 7'h00});
    seen <= 16'h0000;
    touch <= 1'b1;
    while (seen[0] !== 1'b1) begin
      @(posedge i_core_clk);
      n++;
      if (n > 300) hang();
    end
    chk(n >= 20, 32'h1);
    chk({31'h0, tirq_n}, 32'h1);
    touch <= 1'b0;
    poll(ADDR_SCAN_STAT, 16'h8000, 16'h0000);
    av(1'b1, ADDR_ADC_CTRL, 16'h0000);
  endtask
  task automatic t_key();
    kr <= 2'h2;
    kc <= 2'h1;
    kdn <= 1'b1;
    wlow(1'b1);
    av(1'b0, ADDR_KEY_PEND, 16'h0000);
    chk(q, 32'h0);
    av(1'b1, ADDR_KEY_CTRL, 16'h0800);
    poll(ADDR_KEY_PEND, 16'h0040, 16'h0040);
    chk(pn >= 27, 32'h1);
    av(1'b1, ADDR_KEY_MASK, 16'h0040);
    av(1'b0, ADDR_KEY_STATUS, 16'h0000);
    chk(q & 32'h40, 32'h0);
    av(1'b0, ADDR_KEY_PEND, 16'h0000);
    chk(q & 32'h40, 32'h40);
    av(1'b1, ADDR_KEY_MASK, 16'h0000);
    kdn <= 1'b0;
    poll(ADDR_KEY_STATUS, 16'h0040, 16'h0040);
    poll(ADDR_SCAN_STAT, 16'h4000, 16'h0000);
    av(1'b1, ADDR_KEY_CTRL, 16'h8000);
    kr <= 2'h0;
    kc <= 2'h3;
    kdn <= 1'b1;
    poll(ADDR_KEY_PEND, 16'h1000, 16'h1000);
    chk({31'h0, kirq_n}, 32'h1);
    kdn <= 1'b0;
    poll(ADDR_SCAN_STAT, 16'h4000, 16'h0000);
    av(1'b1, ADDR_KEY_CTRL, 16'h0000);
  endtask
  task automatic t_gpio();
    ext_n <= 8'hBF;
    av(1'b1, ADDR_GPIO_CTRL, 16'hF030);
    av(1'b1, ADDR_GPIO_DATA, 16'hA000);
    av(1'b0, ADDR_GPIO_CTRL, 16'h0000);
    chk(q, 32'hF030);
    av(1'b0, ADDR_GPIO_DATA, 16'h0000);
    chk(q & 32'hF000, 32'hA000);
    chk({26'h0, poe_n[7:4], pout[5:4]}, 32'h32);
    av(1'b1, ADDR_GPIO_PUD, 16'h2000);
    av(1'b0, ADDR_GPIO_PUD, 16'h0000);
    chk({30'h0, poe_n[5:4]}, 32'h2);
    av(1'b1, ADDR_GPIO_DATA, 16'h0000);
    av(1'b0, ADDR_GPIO_PUD, 16'h0000);
    chk({28'h0, poe_n[5:4], pout[5:4]}, 32'h0);
    av(1'b1, ADDR_GPIO_PUD, 16'h0000);
  endtask
  task automatic t_serial();
    host.xfer({11'h000, ADDR_GPIO_DATA, 16'h1000}, rd16);
    av(1'b0, ADDR_GPIO_CTRL, 16'h0000);
    chk({30'h0, pout[5:4]}, 32'h1);
    host.xfer({1'b1, 10'h000, ADDR_GPIO_DATA, 16'h0000}, rd16);
    chk({28'h0, rd16[15:12]}, 32'h9);
  endtask
  initial begin
    repeat (16) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    t_regs();
    t_hk();
    t_thost();
    t_tauto();
    t_key();
    t_gpio();
    t_serial();
    tally_and_finish();
  end
endmodule
